// *** design/xssr_pkg.sv ***
// Constants, layouts and types for the state save/restore engine.
// Assumes a 64-bit word memory port and a plain 32-bit register port.
package xssr_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;

  ////////////////////////////////////////////////////////////////////////////
  // Save area layout
  localparam logic [ADDR_W-1:0] HDR_OFF = 32'h0000_0200;
  localparam logic [ADDR_W-1:0] PTR_IP_OFF = 32'h0000_0008;
  localparam logic [ADDR_W-1:0] MEDIA_OFF = 32'h0000_0018;
  localparam logic [ADDR_W-1:0] ST_OFF = 32'h0000_0020;
  localparam logic [ADDR_W-1:0] IGN_LO = 32'h0000_01D0;
  localparam logic [ADDR_W-1:0] IGN_HI = 32'h0000_01FF;
  localparam logic [31:0] MEDIA_SUPPORT_MASK = 32'h0000_FFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Initial values and fields
  localparam logic [DATA_W-1:0] X87_INIT_W0 = 64'h0000_0000_0000_037F;
  localparam logic [DATA_W-1:0] FER_RESET = 64'h0000_0000_0000_0001;
  localparam int FSW_ES_BIT = 23;
  localparam int SEL_LO = 32;
  localparam int SEL_HI = 47;

  ////////////////////////////////////////////////////////////////////////////
  // Component table, ascending presence bit order
  localparam int NCOMP = 7;
  localparam int NARCH = 90;
  localparam logic [2:0] CI_X87 = 3'h0;
  localparam logic [2:0] CI_VEC = 3'h1;
  localparam logic [2:0] CI_UPR = 3'h2;
  localparam logic [2:0] CI_END = 3'h7;
  localparam logic [5:0] X87_PTR_LAST = 6'h02;
  localparam logic [5:0] COMP_BIT [NCOMP] = '{
    6'h00, 6'h01, 6'h02, 6'h09, 6'h0B, 6'h0C, 6'h0F};
  localparam logic [6:0] COMP_BASE [NCOMP] = '{
    7'h00, 7'h13, 7'h33, 7'h53, 7'h54, 7'h56, 7'h59};
  localparam logic [5:0] COMP_NW [NCOMP] = '{
    6'h13, 6'h21, 6'h21, 6'h01, 6'h02, 6'h03, 6'h01};
  localparam logic [ADDR_W-1:0] COMP_OFF [NCOMP] = '{
    32'h0000_0000, 32'h0000_00A0, 32'h0000_0240, 32'h0000_0340,
    32'h0000_0348, 32'h0000_0358, 32'h0000_0370};
  localparam logic [DATA_W-1:0] IMPL_MASK = 64'h0000_0000_0000_9A07;
  localparam logic [3:0] HI_REG_FIRST = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Register port map
  localparam logic [7:0] REG_FER_LO = 8'h00;
  localparam logic [7:0] REG_FER_HI = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_HDR_LO = 8'h10;
  localparam logic [7:0] REG_HDR_HI = 8'h14;
  localparam int CTRL_MODE64 = 0;
  localparam int CTRL_PTRCAP = 1;
  localparam int CTRL_OP32 = 2;

  typedef enum logic [1:0] {
    XSSR_SAVE, XSSR_RESTORE, XSSR_OPT_SAVE
  } xssr_op_e;

  typedef enum logic [3:0] {
    XSSR_IDLE, XSSR_HDR_RD, XSSR_HDR_WT, XSSR_PICK, XSSR_STEP,
    XSSR_MEM_W, XSSR_MEM_R, XSSR_HDR_WR, XSSR_FIN
  } xssr_fsm_e;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } xssr_mreq_s;

endpackage

// *** design/xssr_engine.sv ***
// State save/restore engine: walks selected components between the
// architectural state and a memory save image.
// Assumes memory answers reads in order on the response port; one read
// is outstanding at a time.
//
// Overview of operation
// - Header sits at byte 512; its first word is the presence vector.
// - Presence bit positions match feature enable register bit positions.
// - Saving a component sets its presence bit in the header.
// - Save changes only presence bits selected by mask AND feature enables.
// - Restore updates a component only if mask and enable bits set.
// - Presence set loads from memory; clear forces hardware initial value.
// - x87 init: control 037F, status 0, tags empty, pointers, stack zero.
// - Vector registers initialize to zero, sixteen or eight by mode.
// - Wide vector upper halves initialize to zero, sixteen or eight.
// - Init disables profiling, clears key and shadow stack registers.
// - Media control word has no init; read when vector parts update.
// - Capability clear: pointers skipped unless a math fault pends.
// - Capability set: always restore pointers; save zeros without fault.
// - Outside 64-bit mode vector and upper registers 8-15 untouched.
// - Restore ignores legacy image bytes 464 through 511.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module xssr_engine #(
  parameter int BUF_DEPTH = 2,
  parameter int BUF_W = 64
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Command from pipeline
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire xssr_pkg::xssr_op_e cmd_op_in,
  input wire logic [63:0] cmd_mask_in,
  input wire logic [xssr_pkg::ADDR_W-1:0] cmd_base_in,
  output logic done_out,
  // Architectural state access
  input wire logic arch_wr_in,
  input wire logic [6:0] arch_idx_in,
  input wire logic [63:0] arch_wdata_in,
  output logic [63:0] arch_rdata_out,
  output logic [31:0] media_ctrl_status_out,
  // Memory requests
  output logic mem_req_valid_out,
  input wire logic mem_req_ready_in,
  output xssr_pkg::xssr_mreq_s mem_req_out,
  // Memory responses
  input wire logic mem_rsp_valid_in,
  output logic mem_rsp_ready_out,
  input wire logic [BUF_W-1:0] mem_rsp_data_in
);

  localparam int AW = xssr_pkg::ADDR_W;
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  typedef struct packed {
    xssr_pkg::xssr_fsm_e fsm;
    xssr_pkg::xssr_op_e op;
    logic [63:0] rfbm;
    logic [63:0] hdr;
    logic [AW-1:0] base;
    logic [2:0] comp;
    logic [5:0] widx;
    logic [63:0] fer;
    logic mode64;
    logic ptrcap;
    logic op32;
    logic [xssr_pkg::NARCH-1:0][63:0] arch;
    logic [31:0] media;
    logic req_v;
    xssr_pkg::xssr_mreq_s req;
    logic done;
    logic [31:0] rdata;
    logic [63:0] arch_q;
    logic [BUF_DEPTH-1:0][BUF_W-1:0] buf_mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } xssr_st_s;

  xssr_st_s q_ff;
  xssr_st_s nxt_q;

  logic m_vecup;
  logic m_media;
  logic m_ptr;
  logic m_hireg;
  logic m_ign;
  logic [5:0] m_k;
  logic [6:0] m_aidx;
  logic [AW-1:0] m_off;
  logic [5:0] m_bit;
  logic es_now;
  logic buf_push;
  logic buf_pop;
  logic buf_valid;
  logic [BUF_W-1:0] buf_head;

  ////////////////////////////////////////////////////////////////////////////
  // Word map for the current component and word
  always_comb begin
    m_vecup = (q_ff.comp == xssr_pkg::CI_VEC) ||
              (q_ff.comp == xssr_pkg::CI_UPR);
    m_media = m_vecup && (q_ff.widx == 6'h00);
    m_k = m_vecup ? (q_ff.widx - 6'h01) : q_ff.widx;
    m_ptr = (q_ff.comp == xssr_pkg::CI_X87) && (q_ff.widx != 6'h00) &&
            (q_ff.widx <= xssr_pkg::X87_PTR_LAST);
    m_hireg = m_vecup && !m_media && !q_ff.mode64 &&
              (m_k[4:1] >= xssr_pkg::HI_REG_FIRST);
    m_aidx = 7'h00;
    m_off = '0;
    m_bit = 6'h00;
    if (q_ff.comp < 3'(xssr_pkg::NCOMP)) begin
      m_aidx = xssr_pkg::COMP_BASE[q_ff.comp] + 7'(m_k);
      m_bit = xssr_pkg::COMP_BIT[q_ff.comp];
      if (m_media) begin
        m_off = xssr_pkg::MEDIA_OFF;
      end else if ((q_ff.comp == xssr_pkg::CI_X87) &&
                   (q_ff.widx > xssr_pkg::X87_PTR_LAST)) begin
        m_off = xssr_pkg::ST_OFF +
                AW'({q_ff.widx - 6'h03, 3'b000});
      end else begin
        m_off = xssr_pkg::COMP_OFF[q_ff.comp] + AW'({m_k, 3'b000});
      end
    end
    m_ign = (m_off >= xssr_pkg::IGN_LO) && (m_off <= xssr_pkg::IGN_HI);
    es_now = q_ff.arch[0][xssr_pkg::FSW_ES_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response buffer
  assign buf_valid = (q_ff.cnt != '0);
  assign buf_head = q_ff.buf_mem[q_ff.rp];
  assign mem_rsp_ready_out = (q_ff.cnt < (PW + 1)'(BUF_DEPTH));
  assign buf_push = mem_rsp_valid_in && mem_rsp_ready_out;
  assign buf_pop = buf_valid && !q_ff.req_v &&
                   ((q_ff.fsm == xssr_pkg::XSSR_HDR_WT) ||
                    (q_ff.fsm == xssr_pkg::XSSR_MEM_R));

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [63:0] val;
    val = '0;
    nxt_q = q_ff;
    nxt_q.done = 1'b0;

    if (buf_push) begin
      nxt_q.buf_mem[q_ff.wp] = mem_rsp_data_in;
      nxt_q.wp = (q_ff.wp == PW'(BUF_DEPTH - 1)) ? '0 : q_ff.wp + 1'b1;
    end
    if (buf_pop) begin
      nxt_q.rp = (q_ff.rp == PW'(BUF_DEPTH - 1)) ? '0 : q_ff.rp + 1'b1;
    end
    nxt_q.cnt = q_ff.cnt + (PW + 1)'(buf_push) - (PW + 1)'(buf_pop);

    if (q_ff.req_v && mem_req_ready_in) begin
      nxt_q.req_v = 1'b0;
    end

    if (reg_rd_in) begin
      unique case (reg_addr_in)
        xssr_pkg::REG_FER_LO: nxt_q.rdata = q_ff.fer[31:0];
        xssr_pkg::REG_FER_HI: nxt_q.rdata = q_ff.fer[63:32];
        xssr_pkg::REG_CTRL: nxt_q.rdata = {29'h0, q_ff.op32,
                                           q_ff.ptrcap, q_ff.mode64};
        xssr_pkg::REG_STATUS: nxt_q.rdata = {29'h0, q_ff.op,
                                  q_ff.fsm != xssr_pkg::XSSR_IDLE};
        xssr_pkg::REG_HDR_LO: nxt_q.rdata = q_ff.hdr[31:0];
        xssr_pkg::REG_HDR_HI: nxt_q.rdata = q_ff.hdr[63:32];
        default: nxt_q.rdata = 32'h0000_0000;
      endcase
    end

    nxt_q.arch_q = (arch_idx_in < 7'(xssr_pkg::NARCH)) ?
                   q_ff.arch[arch_idx_in] : {32'h0, q_ff.media};

    unique case (q_ff.fsm)
      xssr_pkg::XSSR_IDLE: begin
        if (reg_wr_in) begin
          if (reg_addr_in == xssr_pkg::REG_FER_LO) begin
            nxt_q.fer[31:0] = reg_wdata_in | xssr_pkg::FER_RESET[31:0];
          end
          if (reg_addr_in == xssr_pkg::REG_FER_HI) begin
            nxt_q.fer[63:32] = reg_wdata_in;
          end
          if (reg_addr_in == xssr_pkg::REG_CTRL) begin
            nxt_q.mode64 = reg_wdata_in[xssr_pkg::CTRL_MODE64];
            nxt_q.ptrcap = reg_wdata_in[xssr_pkg::CTRL_PTRCAP];
            nxt_q.op32 = reg_wdata_in[xssr_pkg::CTRL_OP32];
          end
        end
        if (arch_wr_in) begin
          if (arch_idx_in < 7'(xssr_pkg::NARCH)) begin
            nxt_q.arch[arch_idx_in] = arch_wdata_in;
          end else begin
            nxt_q.media = arch_wdata_in[31:0];
          end
        end
        if (cmd_valid_in) begin
          nxt_q.op = cmd_op_in;
          nxt_q.rfbm = cmd_mask_in & q_ff.fer & xssr_pkg::IMPL_MASK;
          nxt_q.base = cmd_base_in;
          nxt_q.req_v = 1'b1;
          nxt_q.req = '{write: 1'b0, addr: cmd_base_in + xssr_pkg::HDR_OFF,
                        wdata: 64'h0};
          nxt_q.fsm = xssr_pkg::XSSR_HDR_RD;
        end
      end
      xssr_pkg::XSSR_HDR_RD: begin
        if (mem_req_ready_in) begin
          nxt_q.fsm = xssr_pkg::XSSR_HDR_WT;
        end
      end
      xssr_pkg::XSSR_HDR_WT: begin
        if (buf_pop) begin
          nxt_q.hdr = buf_head;
          nxt_q.comp = 3'h0;
          nxt_q.fsm = xssr_pkg::XSSR_PICK;
        end
      end
      xssr_pkg::XSSR_PICK: begin
        if (q_ff.comp == 3'(xssr_pkg::NCOMP)) begin
          nxt_q.comp = xssr_pkg::CI_END;
          if (q_ff.op == xssr_pkg::XSSR_RESTORE) begin
            nxt_q.fsm = xssr_pkg::XSSR_FIN;
          end else begin
            nxt_q.hdr = (q_ff.hdr & ~q_ff.rfbm) | q_ff.rfbm;
            nxt_q.req_v = 1'b1;
            nxt_q.req = '{write: 1'b1,
                          addr: q_ff.base + xssr_pkg::HDR_OFF,
                          wdata: (q_ff.hdr & ~q_ff.rfbm) | q_ff.rfbm};
            nxt_q.fsm = xssr_pkg::XSSR_HDR_WR;
          end
        end else if (q_ff.rfbm[m_bit]) begin
          nxt_q.widx = 6'h00;
          nxt_q.fsm = xssr_pkg::XSSR_STEP;
        end else begin
          nxt_q.comp = q_ff.comp + 3'h1;
        end
      end
      xssr_pkg::XSSR_STEP: begin
        if (q_ff.widx == xssr_pkg::COMP_NW[q_ff.comp]) begin
          nxt_q.comp = q_ff.comp + 3'h1;
          nxt_q.fsm = xssr_pkg::XSSR_PICK;
        end else if (m_hireg || m_ign) begin
          nxt_q.widx = q_ff.widx + 6'h01;
        end else if (q_ff.op != xssr_pkg::XSSR_RESTORE) begin
          if (m_ptr && !q_ff.ptrcap && !es_now) begin
            nxt_q.widx = q_ff.widx + 6'h01;
          end else begin
            if (m_media) begin
              val = {xssr_pkg::MEDIA_SUPPORT_MASK, q_ff.media};
            end else if (m_ptr && !es_now) begin
              val = 64'h0;
            end else if (m_ptr && !(q_ff.mode64 && !q_ff.op32)) begin
              val = {16'h0, q_ff.arch[m_aidx][xssr_pkg::SEL_HI:
                     xssr_pkg::SEL_LO], q_ff.arch[m_aidx][31:0]};
            end else begin
              val = q_ff.arch[m_aidx];
            end
            nxt_q.req_v = 1'b1;
            nxt_q.req = '{write: 1'b1, addr: q_ff.base + m_off, wdata: val};
            nxt_q.fsm = xssr_pkg::XSSR_MEM_W;
          end
        end else if (!q_ff.hdr[m_bit] && !m_media) begin
          nxt_q.arch[m_aidx] = (m_aidx == 7'h00) ?
                               xssr_pkg::X87_INIT_W0 : 64'h0;
          nxt_q.widx = q_ff.widx + 6'h01;
        end else if (m_ptr && !q_ff.ptrcap && !es_now) begin
          nxt_q.widx = q_ff.widx + 6'h01;
        end else begin
          nxt_q.req_v = 1'b1;
          nxt_q.req = '{write: 1'b0, addr: q_ff.base + m_off,
                        wdata: 64'h0};
          nxt_q.fsm = xssr_pkg::XSSR_MEM_R;
        end
      end
      xssr_pkg::XSSR_MEM_W: begin
        if (mem_req_ready_in) begin
          nxt_q.widx = q_ff.widx + 6'h01;
          nxt_q.fsm = xssr_pkg::XSSR_STEP;
        end
      end
      xssr_pkg::XSSR_MEM_R: begin
        if (buf_pop) begin
          val = buf_head;
          if (m_media) begin
            nxt_q.media = val[31:0];
          end else begin
            if (m_ptr && q_ff.ptrcap && q_ff.mode64 && q_ff.op32) begin
              val[xssr_pkg::SEL_HI:xssr_pkg::SEL_LO] = 16'h0000;
            end
            nxt_q.arch[m_aidx] = val;
          end
          nxt_q.widx = q_ff.widx + 6'h01;
          nxt_q.fsm = xssr_pkg::XSSR_STEP;
        end
      end
      xssr_pkg::XSSR_HDR_WR: begin
        if (mem_req_ready_in) begin
          nxt_q.fsm = xssr_pkg::XSSR_FIN;
        end
      end
      xssr_pkg::XSSR_FIN: begin
        nxt_q.done = 1'b1;
        nxt_q.fsm = xssr_pkg::XSSR_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q_ff <= '0;
      q_ff.fsm <= xssr_pkg::XSSR_IDLE;
      q_ff.op <= xssr_pkg::XSSR_SAVE;
      q_ff.fer <= xssr_pkg::FER_RESET;
      q_ff.arch[0] <= xssr_pkg::X87_INIT_W0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_out = q_ff.rdata;
  assign cmd_ready_out = (q_ff.fsm == xssr_pkg::XSSR_IDLE);
  assign done_out = q_ff.done;
  assign arch_rdata_out = q_ff.arch_q;
  assign media_ctrl_status_out = q_ff.media;
  assign mem_req_valid_out = q_ff.req_v;
  assign mem_req_out = q_ff.req;

endmodule

// *** tb/xssr_engine_asserts.sv ***
// Port checker for the save/restore engine.
// Assumes one save area base per operation, taken with the command.
`timescale 1ns/1ps
module xssr_engine_asserts (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Command
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic [xssr_pkg::ADDR_W-1:0] cmd_base_in,
  input wire logic done_out,
  input wire logic [31:0] media_ctrl_status_out,
  // Memory
  input wire logic mem_req_valid_out,
  input wire logic mem_req_ready_in,
  input wire xssr_pkg::xssr_mreq_s mem_req_out,
  input wire logic mem_rsp_valid_in,
  input wire logic mem_rsp_ready_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [31:0] base_ff;
  logic pend_ff;
  wire logic [31:0] offs = mem_req_out.addr - base_ff;
  wire logic take = cmd_valid_in && cmd_ready_out;
  always_ff @(posedge clk_in) begin
    if (take) begin
      base_ff <= cmd_base_in;
    end
    if (rst_in) begin
      pend_ff <= 1'b0;
    end else if (mem_req_valid_out && mem_req_ready_in
                 && !mem_req_out.write) begin
      pend_ff <= 1'b1;
    end else if (mem_rsp_valid_in && mem_rsp_ready_out) begin
      pend_ff <= 1'b0;
    end
  end
  a_hdr_first: assert property (take |=> mem_req_valid_out
    && !mem_req_out.write && offs == xssr_pkg::HDR_OFF)
    else $error("first request not a header read");
  a_done_pulse: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  a_cmd_busy: assert property (take |=> !cmd_ready_out)
    else $error("ready stayed high after command");
  a_req_stable: assert property (mem_req_valid_out && !mem_req_ready_in
    |=> mem_req_valid_out && $stable(mem_req_out))
    else $error("request changed before acceptance");
  a_word_align: assert property (mem_req_valid_out
    |-> mem_req_out.addr[2:0] == 3'h0)
    else $error("unaligned memory request");
  a_ignore_area: assert property (mem_req_valid_out
    |-> !(offs >= xssr_pkg::IGN_LO && offs <= xssr_pkg::IGN_HI))
    else $error("access to software area");
  a_media_word: assert property (mem_req_valid_out && mem_req_out.write
    && offs == xssr_pkg::MEDIA_OFF |-> mem_req_out.wdata ==
    {xssr_pkg::MEDIA_SUPPORT_MASK, media_ctrl_status_out})
    else $error("media word wrong");
  a_one_read: assert property (pend_ff |-> !mem_req_valid_out)
    else $error("request while read pending");
  c_done: cover property (done_out);
  c_stall: cover property (mem_req_valid_out && !mem_req_ready_in);
  c_media: cover property (mem_req_valid_out && offs == 32'h0000_0018);
endmodule
bind xssr_engine xssr_engine_asserts u_chk (.clk_in(clk_in),
  .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
  .cmd_ready_out(cmd_ready_out), .cmd_base_in(cmd_base_in),
  .done_out(done_out), .media_ctrl_status_out(media_ctrl_status_out),
  .mem_req_valid_out(mem_req_valid_out),
  .mem_req_ready_in(mem_req_ready_in), .mem_req_out(mem_req_out),
  .mem_rsp_valid_in(mem_rsp_valid_in),
  .mem_rsp_ready_out(mem_rsp_ready_out));

// *** tb/xssr_mem_model.sv ***
// Word memory holding the save image behind the engine.
// Assumes one read outstanding; slow_in stalls requests and delays data.
`timescale 1ns/1ps
module xssr_mem_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  // Requests
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire xssr_pkg::xssr_mreq_s req_in,
  // Responses
  output logic rsp_valid_out,
  input wire logic rsp_ready_in,
  output logic [63:0] rsp_data_out
);
  logic [63:0] mem [128];
  logic [63:0] last_ff;
  logic tog_ff;
  logic pend_ff;
  logic [1:0] wait_ff;
  assign req_ready_out = !slow_in || tog_ff;
  assign rsp_valid_out = pend_ff && wait_ff == 2'h0;
  // Released data lines show the inverse
  assign rsp_data_out = rsp_valid_out ? last_ff : ~last_ff;
  // Plain process: the bench preloads the image array directly
  always @(posedge clk_in) begin
    if (rst_in) begin
      pend_ff <= 1'b0;
      wait_ff <= 2'h0;
      tog_ff <= 1'b0;
    end else begin
      tog_ff <= !tog_ff;
      if (wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end
      if (rsp_valid_out && rsp_ready_in) begin
        pend_ff <= 1'b0;
      end
      if (req_valid_in && req_ready_out) begin
        if (req_in.write) begin
          mem[req_in.addr[9:3]] <= req_in.wdata;
        end else begin
          pend_ff <= 1'b1;
          wait_ff <= slow_in ? 2'h3 : 2'h0;
          last_ff <= mem[req_in.addr[9:3]];
        end
      end
    end
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the save/restore engine and memory model.
// Assumes save area base 0x1000, so image word j is memory index j.
`timescale 1ns/1ps
module testbench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  xssr_pkg::xssr_op_e cmd_op_in = xssr_pkg::XSSR_SAVE;
  logic [63:0] cmd_mask_in = 64'h0;
  logic arch_wr_in = 1'b0;
  logic [6:0] arch_idx_in = 7'h00;
  logic [63:0] arch_wdata_in = 64'h0;
  logic slow = 1'b0;
  logic [31:0] reg_rdata_out, media_out, rd;
  logic cmd_ready_out, done_out, mreq_v, mreq_r, rsp_v, rsp_r;
  logic [63:0] arch_rdata_out, rsp_d, ad;
  xssr_pkg::xssr_mreq_s mreq;
  int err_total = 0;
  int checks_done = 0;
  localparam logic [63:0] EE = 64'hEEEE_EEEE_EEEE_EEEE;
  localparam logic [63:0] W0 = 64'h0000_0055_0080_027F;
  initial begin
    forever #12.5 clk_in = !clk_in;
  end
  xssr_engine u_dut (.clk_in(clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .cmd_valid_in(cmd_valid_in),
    .cmd_ready_out(cmd_ready_out), .cmd_op_in(cmd_op_in),
    .cmd_mask_in(cmd_mask_in), .cmd_base_in(32'h0000_1000),
    .done_out(done_out), .arch_wr_in(arch_wr_in),
    .arch_idx_in(arch_idx_in), .arch_wdata_in(arch_wdata_in),
    .arch_rdata_out(arch_rdata_out), .media_ctrl_status_out(media_out),
    .mem_req_valid_out(mreq_v), .mem_req_ready_in(mreq_r),
    .mem_req_out(mreq), .mem_rsp_valid_in(rsp_v),
    .mem_rsp_ready_out(rsp_r), .mem_rsp_data_in(rsp_d));
  xssr_mem_model u_mem (.clk_in(clk_in), .rst_in(rst_in),
    .slow_in(slow), .req_valid_in(mreq_v), .req_ready_out(mreq_r),
    .req_in(mreq), .rsp_valid_out(rsp_v), .rsp_ready_in(rsp_r),
    .rsp_data_out(rsp_d));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] pat(input int i);
    return {16'h5A5A, i[7:0], 40'h12_3456_789A};
  endfunction
  function automatic int bitof(input int i);
    if (i < 83) return i < 19 ? 0 : (i < 51 ? 1 : 2);
    if (i == 83) return 9;
    return i < 86 ? 11 : (i < 89 ? 12 : 15);
  endfunction
  function automatic int slot(input int i);
    return i < 3 ? i : (i < 51 ? i + 1 : i + 21);
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic reg_w(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic reg_r(input logic [7:0] a);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 rd = reg_rdata_out;
  endtask
  task automatic arch_w(input int i, input logic [63:0] d);
    @(posedge clk_in);
    arch_idx_in <= 7'(i);
    arch_wdata_in <= d;
    arch_wr_in <= 1'b1;
    @(posedge clk_in);
    arch_wr_in <= 1'b0;
  endtask
  task automatic arch_r(input int i);
    @(posedge clk_in);
    arch_idx_in <= 7'(i);
    @(posedge clk_in);
    #1 ad = arch_rdata_out;
  endtask
  task automatic run(input xssr_pkg::xssr_op_e op, input logic [63:0] m);
    int n;
    @(posedge clk_in);
    cmd_op_in <= op;
    cmd_mask_in <= m;
    cmd_valid_in <= 1'b1;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    for (n = 0; n < 5000; n++) begin
      @(posedge clk_in);
      #1;
      if (done_out === 1'b1) break;
    end
    if (n == 5000) begin
      err_total++;
      finish_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [63:0] e;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    reg_r(xssr_pkg::REG_FER_LO);
    chk({32'h0, rd}, 64'h1);
    reg_r(8'h1C);
    chk({32'h0, rd}, 64'h0);
    reg_w(xssr_pkg::REG_FER_LO, 32'h0000_9A07);
    reg_w(xssr_pkg::REG_CTRL, 32'h0000_0003);
    reg_r(xssr_pkg::REG_FER_LO);
    chk({32'h0, rd}, 64'h9A07);
    for (int i = 0; i < 90; i++) arch_w(i, i == 0 ? W0 : pat(i));
    arch_w(90, 64'h1F80);
    for (int j = 0; j < 128; j++) u_mem.mem[j] = EE;
    u_mem.mem[64] = 64'h8000_0000_0000_1000;
    slow <= 1'b1;
    run(xssr_pkg::XSSR_SAVE, 64'hFFFF_FFFF_FFFF_6FFF);
    chk(u_mem.mem[64], 64'h8000_0000_0000_1A07);
    chk(u_mem.mem[3], 64'h0000_FFFF_0000_1F80);
    chk(u_mem.mem[58], EE);
    for (int i = 0; i < 90; i++) begin
      e = (bitof(i) > 11) ? EE : (i == 0 ? W0 : pat(i));
      chk(u_mem.mem[slot(i)], e);
    end
    // Image edited by software with its presence bits
    u_mem.mem[64] = 64'h0000_0000_0000_0202;
    u_mem.mem[3] = 64'h0000_FFFF_0000_1FA0;
    for (int i = 0; i < 90; i++) arch_w(i, ~pat(i));
    slow <= 1'b0;
    run(xssr_pkg::XSSR_RESTORE, 64'hFFFF_FFFF_FFFF_7FFF);
    chk({32'h0, media_out}, 64'h1FA0);
    arch_r(90);
    chk(ad, 64'h1FA0);
    for (int i = 0; i < 90; i++) begin
      if (bitof(i) == 15) e = ~pat(i);
      else if (bitof(i) == 1 || bitof(i) == 9) e = pat(i);
      else e = (i == 0) ? xssr_pkg::X87_INIT_W0 : 64'h0;
      arch_r(i);
      chk(ad, e);
    end
    // Legacy mode, no pointer capability, area already initialised
    reg_w(xssr_pkg::REG_CTRL, 32'h0000_0000);
    for (int j = 0; j < 128; j++) u_mem.mem[j] = EE;
    run(xssr_pkg::XSSR_OPT_SAVE, 64'h3);
    chk(u_mem.mem[64], 64'hEEEE_EEEE_EEEE_EEEF);
    for (int i = 0; i < 51; i++) begin
      if (i == 1 || i == 2 || i > 34) e = EE;
      else e = (i == 0) ? xssr_pkg::X87_INIT_W0 : (i < 19 ? 64'h0 : pat(i));
      chk(u_mem.mem[slot(i)], e);
    end
    // Pointers with capability and 32-bit operands
    reg_w(xssr_pkg::REG_CTRL, 32'h0000_0007);
    run(xssr_pkg::XSSR_SAVE, 64'h1);
    chk(u_mem.mem[1], 64'h0);
    chk(u_mem.mem[2], 64'h0);
    arch_w(0, W0);
    arch_w(1, pat(1));
    arch_w(2, pat(2));
    run(xssr_pkg::XSSR_SAVE, 64'h1);
    chk(u_mem.mem[1], pat(1) & 64'h0000_FFFF_FFFF_FFFF);
    chk(u_mem.mem[2], pat(2) & 64'h0000_FFFF_FFFF_FFFF);
    arch_w(1, EE);
    run(xssr_pkg::XSSR_RESTORE, 64'h1);
    arch_r(1);
    chk(ad, pat(1) & 64'h0000_0000_FFFF_FFFF);
    // Legacy restore without capability and no pending fault
    reg_w(xssr_pkg::REG_CTRL, 32'h0000_0000);
    u_mem.mem[0] = xssr_pkg::X87_INIT_W0;
    arch_w(1, EE);
    arch_w(50, 64'h0);
    run(xssr_pkg::XSSR_RESTORE, 64'h3);
    arch_r(1);
    chk(ad, EE);
    arch_r(50);
    chk(ad, 64'h0);
    arch_r(0);
    chk(ad, xssr_pkg::X87_INIT_W0);
    reg_r(xssr_pkg::REG_HDR_LO);
    chk({32'h0, rd}, 64'hEEEE_EEEF);
    finish_test();
  end
endmodule
